// [ghp_host_port.sv]
// Purpose: Host-facing side of a positioning receiver: serial port, I2C target, timing pulse, power state
// Assumes: One 200 MHz clock; all pins pass two flip-flops before use
// Notes: Core firmware supplies reports, consumes commands and reports fix state
// Summary of operation
// - Selectable bit rate, starts at 9600
// - No hardware flow control on serial link
// - Transmit line idles high
// - Reports go out on transmit line
// - Commands and images arrive on receive line
// - I2C is target only, host clocks
// - Answer one 7-bit target address
// - Timing pulse held off until 3D fix
// - Pulse width, period, phase, disable configurable
// - Power-hold low enters RTC low-power mode
// - Power-hold high resumes full operation
// - Undriven power-hold reads high, full power
// - Active status high at full power
// - Active status low in RTC or periodic
// - Supply loss restores factory defaults
`timescale 1ns/1ps
module ghp_host_port (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] rate_sel_i,
    input wire logic rate_load_i,
    output logic [3:0] rate_sel_o,
    input wire ghp_pkg::ghp_byte_t tx_byte_i,
    output logic tx_ready_o,
    output logic uart_tx_o,
    input wire logic uart_rx_i,
    output ghp_pkg::ghp_byte_t rx_byte_o,
    output logic rx_frame_err_o,
    input wire logic [6:0] tgt_addr_i,
    input wire logic tgt_addr_load_i,
    input wire logic i2c_scl_i,
    input wire logic i2c_sda_i,
    output logic i2c_sda_o,
    output logic i2c_sda_oe_o,
    output ghp_pkg::ghp_byte_t i2c_wr_byte_o,
    input wire logic [7:0] i2c_rd_data_i,
    output logic i2c_rd_take_o,
    input wire logic fix_3d_i,
    input wire ghp_pkg::ghp_pps_cfg_t pps_cfg_i,
    input wire logic pps_cfg_load_i,
    output logic pulse_per_second_output_o,
    input wire logic power_hold_i,
    input wire logic periodic_mode_i,
    output logic rtc_mode_o,
    output logic active_o
);
    localparam logic [15:0] ONE = 16'h0001;
    logic [3:0] rate_r;
    logic [15:0] div_w;
    logic [1:0] rx_sync_r, scl_sync_r, sda_sync_r, hold_sync_r;
    logic rx_s, scl_s, sda_s, scl_d_r, sda_d_r;

    // Two-flop synchronisers; only the second stage is read. Power-hold resets high as the pull-up would
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rx_sync_r <= 2'h3;
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            hold_sync_r <= 2'h3;
        end
        else
        begin
            rx_sync_r <= {rx_sync_r[0], uart_rx_i};
            scl_sync_r <= {scl_sync_r[0], i2c_scl_i};
            sda_sync_r <= {sda_sync_r[0], i2c_sda_i};
            hold_sync_r <= {hold_sync_r[0], power_hold_i};
        end
    end
    assign rx_s = rx_sync_r[1];
    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];

    // Bit-rate select; reset is the factory default
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rate_r <= ghp_pkg::RATE_SEL_RESET;
        else if (rate_load_i && rate_sel_i <= ghp_pkg::RATE_SEL_MAX)
            rate_r <= rate_sel_i;
    end
    assign rate_sel_o = rate_r;
    assign div_w = ghp_pkg::bit_div(rate_r);

    // Power state follows the synchronised hold level
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rtc_mode_o <= 1'b0;
            active_o <= 1'b1;
        end
        else
        begin
            rtc_mode_o <= !hold_sync_r[1];
            active_o <= hold_sync_r[1] && !periodic_mode_i;
        end
    end

    // Serial transmitter; byte taken only when idle, no RTS/CTS exists
    logic [9:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic [15:0] tx_div_r;
    assign tx_ready_o = (tx_cnt_r == 4'h0) && !rtc_mode_o;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_sh_r <= 10'h3FF;
            tx_cnt_r <= 4'h0;
            tx_div_r <= 16'h0000;
            uart_tx_o <= 1'b1;
        end
        else if (tx_cnt_r == 4'h0)
        begin
            uart_tx_o <= 1'b1;
            if (tx_byte_i.valid && tx_ready_o)
            begin
                tx_sh_r <= {1'b1, tx_byte_i.data, 1'b0}; // Start, LSB-first data, stop
                tx_cnt_r <= 4'hB; // One extra shift so the stop bit lasts a full bit before ready
                tx_div_r <= 16'h0000;
            end
        end
        else if (tx_div_r == 16'h0000)
        begin
            uart_tx_o <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_div_r <= div_w - ONE;
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
        else
            tx_div_r <= tx_div_r - ONE;
    end

    // Serial receiver for commands, corrections and images
    ghp_uart_rx u_rx (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .div_i(div_w),
        .rx_i(rx_s),
        .byte_o(rx_byte_o),
        .frame_err_o(rx_frame_err_o)
    );

    // I2C target: never drives SCL, only reacts to host edges
    typedef enum logic [2:0] {GHP_I2C_IDLE = 3'b000, GHP_I2C_ADDR = 3'b001, GHP_I2C_AACK = 3'b011,
        GHP_I2C_WR = 3'b010, GHP_I2C_WACK = 3'b110, GHP_I2C_RD = 3'b111, GHP_I2C_RACK = 3'b101}
        ghp_i2c_state_t;
    ghp_i2c_state_t i2c_st_r;
    logic [6:0] addr_r;
    logic [7:0] i2c_sh_r;
    logic [3:0] i2c_bit_r;
    logic i2c_rw_r;
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

    // Own address register, default restored on reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            addr_r <= ghp_pkg::TGT_ADDR_RESET;
        else if (tgt_addr_load_i)
            addr_r <= tgt_addr_i;
    end

    // Target bit engine; samples on SCL rise, changes SDA after SCL fall
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            i2c_st_r <= GHP_I2C_IDLE;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            i2c_sh_r <= 8'h00;
            i2c_bit_r <= 4'h0;
            i2c_rw_r <= 1'b0;
            i2c_sda_o <= 1'b1;
            i2c_sda_oe_o <= 1'b0;
            i2c_wr_byte_o <= '0;
            i2c_rd_take_o <= 1'b0;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            i2c_wr_byte_o.valid <= 1'b0;
            i2c_rd_take_o <= 1'b0;
            i2c_sda_o <= 1'b0;
            if (start_c)
            begin
                i2c_st_r <= GHP_I2C_ADDR;
                i2c_bit_r <= 4'h0;
                i2c_sda_oe_o <= 1'b0;
            end
            else if (stop_c || rtc_mode_o)
            begin
                i2c_st_r <= GHP_I2C_IDLE;
                i2c_sda_oe_o <= 1'b0;
            end
            else if (scl_rise && (i2c_st_r == GHP_I2C_ADDR || i2c_st_r == GHP_I2C_WR))
            begin
                i2c_sh_r <= {i2c_sh_r[6:0], sda_s};
                i2c_bit_r <= i2c_bit_r + 4'h1;
            end
            else if (scl_rise && i2c_st_r == GHP_I2C_RACK && sda_s)
                i2c_st_r <= GHP_I2C_IDLE; // Host NACK ends the read
            else if (scl_fall)
            begin
                case (i2c_st_r)
                    GHP_I2C_ADDR:
                    begin
                        if (i2c_bit_r == 4'h8)
                        begin
                            if (i2c_sh_r[7:1] == addr_r) // 7-bit match only
                            begin
                                i2c_st_r <= GHP_I2C_AACK;
                                i2c_rw_r <= i2c_sh_r[0];
                                i2c_sda_oe_o <= 1'b1;
                            end
                            else
                                i2c_st_r <= GHP_I2C_IDLE;
                        end
                    end
                    GHP_I2C_AACK, GHP_I2C_WACK, GHP_I2C_RACK:
                    begin
                        i2c_bit_r <= 4'h0;
                        if (i2c_rw_r)
                        begin
                            i2c_st_r <= GHP_I2C_RD;
                            i2c_sh_r <= {i2c_rd_data_i[6:0], 1'b0};
                            i2c_sda_oe_o <= !i2c_rd_data_i[7];
                            i2c_rd_take_o <= 1'b1;
                            i2c_bit_r <= 4'h1;
                        end
                        else
                        begin
                            i2c_st_r <= GHP_I2C_WR;
                            i2c_sda_oe_o <= 1'b0;
                        end
                    end
                    GHP_I2C_WR:
                    begin
                        if (i2c_bit_r == 4'h8)
                        begin
                            i2c_st_r <= GHP_I2C_WACK;
                            i2c_sda_oe_o <= 1'b1;
                            i2c_wr_byte_o.valid <= 1'b1;
                            i2c_wr_byte_o.data <= i2c_sh_r;
                        end
                    end
                    GHP_I2C_RD:
                    begin
                        if (i2c_bit_r == 4'h8)
                        begin
                            i2c_st_r <= GHP_I2C_RACK;
                            i2c_sda_oe_o <= 1'b0;
                        end
                        else
                        begin
                            i2c_sda_oe_o <= !i2c_sh_r[7]; // Open drain: drive only zeros
                            i2c_sh_r <= {i2c_sh_r[6:0], 1'b0};
                            i2c_bit_r <= i2c_bit_r + 4'h1;
                        end
                    end
                    default: i2c_st_r <= GHP_I2C_IDLE;
                endcase
            end
        end
    end

    // Timing pulse configuration, factory values on reset
    ghp_pkg::ghp_pps_cfg_t pps_cfg_r;
    logic [31:0] pps_cnt_r;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pps_cfg_r.enable <= 1'b1;
            pps_cfg_r.period <= ghp_pkg::PPS_PERIOD_RESET;
            pps_cfg_r.width <= ghp_pkg::PPS_WIDTH_RESET;
            pps_cfg_r.phase <= ghp_pkg::PPS_PHASE_RESET;
        end
        else if (pps_cfg_load_i && pps_cfg_i.period != 32'h00000000)
            pps_cfg_r <= pps_cfg_i;
    end

    // Pulse generator; counter sits at zero until a 3D fix, so phase counts from the fix
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pps_cnt_r <= 32'h00000000;
            pulse_per_second_output_o <= 1'b0;
        end
        else if (!fix_3d_i || !pps_cfg_r.enable || rtc_mode_o)
        begin
            pps_cnt_r <= 32'h00000000;
            pulse_per_second_output_o <= 1'b0;
        end
        else
        begin
            pps_cnt_r <= (pps_cnt_r >= pps_cfg_r.period - 32'h00000001) ? 32'h00000000 : pps_cnt_r + 32'h00000001;
            pulse_per_second_output_o <= (pps_cnt_r >= pps_cfg_r.phase) &&
                (pps_cnt_r < pps_cfg_r.phase + pps_cfg_r.width);
        end
    end
endmodule

// [ghp_pkg.sv]
// Purpose: Shared constants and types for the host port and power-state block
// Assumes: 200 MHz system clock
// Notes: Bit-rate table indexed by a 4-bit select code
package ghp_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned BAUD_19200 = 19200;
    localparam int unsigned BAUD_38400 = 38400;
    localparam int unsigned BAUD_57600 = 57600;
    localparam int unsigned BAUD_115200 = 115200;
    localparam int unsigned BAUD_230400 = 230400;
    localparam int unsigned BAUD_460800 = 460800;
    localparam int unsigned BAUD_921600 = 921600;
    localparam int unsigned BAUD_3000000 = 3000000;
    localparam logic [3:0] RATE_SEL_RESET = 4'h0;
    localparam logic [3:0] RATE_SEL_MAX = 4'h8;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [6:0] TGT_ADDR_RESET = 7'h10;
    localparam logic [31:0] PPS_PERIOD_RESET = 32'h0BEBC200;
    localparam logic [31:0] PPS_WIDTH_RESET = 32'h01312D00;
    localparam logic [31:0] PPS_PHASE_RESET = 32'h00000000;

    typedef struct packed {
        logic enable;
        logic [31:0] period;
        logic [31:0] width;
        logic [31:0] phase;
    } ghp_pps_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ghp_byte_t;

    // Cycles per bit for a select code; unknown codes fall back to the default rate
    function automatic logic [DIV_W-1:0] bit_div(input logic [3:0] sel);
        int unsigned r;
        case (sel)
            4'h0: r = BAUD_9600;
            4'h1: r = BAUD_19200;
            4'h2: r = BAUD_38400;
            4'h3: r = BAUD_57600;
            4'h4: r = BAUD_115200;
            4'h5: r = BAUD_230400;
            4'h6: r = BAUD_460800;
            4'h7: r = BAUD_921600;
            4'h8: r = BAUD_3000000;
            default: r = BAUD_9600;
        endcase
        bit_div = DIV_W'(CLK_HZ / r);
    endfunction
endpackage

// [ghp_uart_rx.sv]
// Purpose: Serial receiver, 8N1, sampling at mid-bit
// Assumes: Rx pin already passed through a two-stage synchroniser
// Notes: No flow control; a bad stop bit raises a one-cycle framing error
`timescale 1ns/1ps
module ghp_uart_rx (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [15:0] div_i,
    input wire logic rx_i,
    output ghp_pkg::ghp_byte_t byte_o,
    output logic frame_err_o
);
    typedef enum logic [1:0] {GHP_RX_IDLE = 2'b00, GHP_RX_START = 2'b01, GHP_RX_DATA = 2'b11,
        GHP_RX_STOP = 2'b10} ghp_rx_state_t;
    ghp_rx_state_t state_r;
    logic [15:0] cnt_r;
    logic [2:0] idx_r;
    logic [7:0] shift_r;

    // Bit framing; start bit is rechecked at half a bit to reject glitches
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= GHP_RX_IDLE;
            cnt_r <= 16'h0000;
            idx_r <= 3'h0;
            shift_r <= 8'h00;
            byte_o <= '0;
            frame_err_o <= 1'b0;
        end
        else
        begin
            byte_o.valid <= 1'b0;
            frame_err_o <= 1'b0;
            case (state_r)
                GHP_RX_IDLE:
                begin
                    if (!rx_i)
                    begin
                        state_r <= GHP_RX_START;
                        cnt_r <= {1'b0, div_i[15:1]};
                    end
                end
                GHP_RX_START:
                begin
                    if (cnt_r != 16'h0000)
                        cnt_r <= cnt_r - 16'h0001;
                    else if (rx_i)
                        state_r <= GHP_RX_IDLE;
                    else
                    begin
                        state_r <= GHP_RX_DATA;
                        cnt_r <= div_i - 16'h0001;
                        idx_r <= 3'h0;
                    end
                end
                GHP_RX_DATA:
                begin
                    if (cnt_r != 16'h0000)
                        cnt_r <= cnt_r - 16'h0001;
                    else
                    begin
                        shift_r <= {rx_i, shift_r[7:1]}; // LSB first
                        cnt_r <= div_i - 16'h0001;
                        if (idx_r == 3'h7)
                            state_r <= GHP_RX_STOP;
                        idx_r <= idx_r + 3'h1;
                    end
                end
                GHP_RX_STOP:
                begin
                    if (cnt_r != 16'h0000)
                        cnt_r <= cnt_r - 16'h0001;
                    else
                    begin
                        state_r <= GHP_RX_IDLE;
                        if (rx_i)
                        begin
                            byte_o.valid <= 1'b1;
                            byte_o.data <= shift_r;
                        end
                        else
                            frame_err_o <= 1'b1;
                    end
                end
                default: state_r <= GHP_RX_IDLE;
            endcase
        end
    end
endmodule

// [ghp_host_port_asserts.sv]
// Purpose: Port-level assertions for the host port and power-state block
// Assumes: One clock, synchronous active-high reset
// Notes: Windows allow for the two-flop pin synchronisers
`timescale 1ns/1ps
module ghp_host_port_asserts (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] rate_sel_i,
    input wire logic rate_load_i,
    input wire logic [3:0] rate_sel_o,
    input wire ghp_pkg::ghp_byte_t tx_byte_i,
    input wire logic tx_ready_o,
    input wire logic uart_tx_o,
    input wire logic i2c_sda_o,
    input wire logic i2c_sda_oe_o,
    input wire logic fix_3d_i,
    input wire logic pulse_per_second_output_o,
    input wire logic power_hold_i,
    input wire logic periodic_mode_i,
    input wire logic rtc_mode_o,
    input wire logic active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Serial port, rate and framing start
    AST_TX_IDLE: assert property (tx_ready_o |-> uart_tx_o) else $error("tx low while idle");
    AST_TX_START: assert property (tx_byte_i.valid && tx_ready_o |=> !tx_ready_o ##1 !uart_tx_o)
        else $error("no start bit");
    AST_RATE_LOAD: assert property (rate_load_i && rate_sel_i <= ghp_pkg::RATE_SEL_MAX |=>
        rate_sel_o == $past(rate_sel_i)) else $error("rate not loaded");
    AST_RATE_BAD: assert property (rate_load_i && rate_sel_i > ghp_pkg::RATE_SEL_MAX |=> $stable(rate_sel_o))
        else $error("bad rate code taken");
    // Power state; repetitions span the pin synchroniser
    AST_RTC_IN: assert property (!power_hold_i [*6] |-> rtc_mode_o) else $error("rtc not entered");
    AST_RTC_OUT: assert property (power_hold_i [*6] |-> !rtc_mode_o) else $error("rtc not left");
    AST_ACT_HI: assert property ((power_hold_i && !periodic_mode_i) [*8] |-> active_o)
        else $error("active low at full power");
    AST_ACT_LO: assert property ((rtc_mode_o or periodic_mode_i [*2]) |-> !active_o)
        else $error("active high in low power");
    AST_TX_RTC: assert property (rtc_mode_o [*2] |-> !tx_ready_o) else $error("tx accepts in rtc");
    // Timing pulse and open-drain data pin
    AST_PPS_FIX: assert property (!fix_3d_i [*2] |-> !pulse_per_second_output_o) else $error("pps without fix");
    AST_PPS_RTC: assert property (rtc_mode_o [*2] |-> !pulse_per_second_output_o) else $error("pps in rtc");
    AST_SDA_OD: assert property (i2c_sda_oe_o |-> !i2c_sda_o) else $error("sda driven high");
    // Main scenarios reached
    cover property (tx_byte_i.valid && tx_ready_o);
    cover property ($rose(rtc_mode_o));
    cover property ($rose(pulse_per_second_output_o));
    cover property ($rose(i2c_sda_oe_o));
endmodule
bind ghp_host_port ghp_host_port_asserts u_chk (.*);

// [ghp_host_model.sv]
// Purpose: Host processor model: serial both ways, I2C controller, power-hold pin
// Assumes: Bench sets div_i to the rate the block is using
// Notes: Behavioural; all changes land 1 ns after a clock edge
`timescale 1ns/1ps
module ghp_host_model (
    input wire logic clk_i,
    input wire logic [15:0] div_i,
    input wire logic uart_tx_i,
    output logic uart_rx_o,
    output logic power_hold_o,
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    logic hold_low = 1'b0;
    logic [7:0] got[$];
    // Pin left undriven reads high through the pull-up
    assign power_hold_o = !hold_low;
    initial
    begin
        uart_rx_o = 1'b1;
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // 8N1, LSB first, no handshake lines at all
    task automatic send_byte(input logic [7:0] d, input logic stop);
        logic [10:0] f;
        f = {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            uart_rx_o = f[i];
            tick(div_i);
        end
    endtask
    // Mid-bit decoder of the report line; a bad stop drops the byte
    always
    begin
        logic [7:0] b;
        @(negedge uart_tx_i);
        tick(div_i / 2);
        for (int i = 0; i < 8; i++)
        begin
            tick(div_i);
            b[i] = uart_tx_i;
        end
        tick(div_i);
        if (uart_tx_i === 1'b1)
            got.push_back(b);
    end
    // Host owns SCL and starts the transfer; 7-bit address, write
    task automatic i2c_probe(input logic [6:0] a, output logic ack);
        logic [7:0] f;
        f = {a, 1'b0};
        sda_low_o = 1'b1;
        tick(50);
        for (int i = 7; i >= 0; i--)
        begin
            scl_o = 1'b0;
            tick(25);
            sda_low_o = !f[i];
            tick(25);
            scl_o = 1'b1;
            tick(50);
        end
        scl_o = 1'b0;
        sda_low_o = 1'b0;
        tick(50);
        scl_o = 1'b1;
        tick(25);
        ack = !sda_i;
        tick(25);
        scl_o = 1'b0;
        sda_low_o = 1'b1;
        tick(50);
        scl_o = 1'b1;
        tick(25);
        sda_low_o = 1'b0;
        tick(50);
    endtask
endmodule

// [ghp_host_port_tb.sv]
// Purpose: Self-checking bench for the host port and power-state block
// Assumes: 200 MHz clock, host model on the far side
// Notes: Slow rates are only timed on the start bit, then reset cuts the frame
`timescale 1ns/1ps
module ghp_host_port_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] rate_sel_i = 4'h0;
    logic rate_load_i = 1'b0;
    ghp_pkg::ghp_byte_t tx_byte_i = '0;
    logic [6:0] tgt_addr_i = 7'h00;
    logic tgt_addr_load_i = 1'b0;
    logic [7:0] i2c_rd_data_i = 8'h00;
    logic fix_3d_i = 1'b0;
    ghp_pkg::ghp_pps_cfg_t pps_cfg_i = '0;
    logic pps_cfg_load_i = 1'b0;
    logic periodic_mode_i = 1'b0;
    logic [3:0] rate_sel_o;
    logic tx_ready_o, uart_tx_o, uart_rx_i, rx_frame_err_o, i2c_scl_i, i2c_sda_o, i2c_sda_oe_o, i2c_rd_take_o;
    logic pulse_per_second_output_o, power_hold_i, rtc_mode_o, active_o, sda_low;
    ghp_pkg::ghp_byte_t rx_byte_o, i2c_wr_byte_o;
    wire logic [15:0] cur_div = 16'(ghp_pkg::CLK_HZ / ghp_pkg::BAUD_3000000);
    // Open-drain data line with pull-up, low if either side pulls
    wire logic i2c_sda_i = !(sda_low || i2c_sda_oe_o);
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    ghp_host_port dut (.*);
    ghp_host_model host (.clk_i(clk_i), .div_i(cur_div), .uart_tx_i(uart_tx_o), .uart_rx_o(uart_rx_i),
        .power_hold_o(power_hold_i), .scl_o(i2c_scl_i), .sda_low_o(sda_low), .sda_i(i2c_sda_i));
    always #2.5 clk_i = !clk_i;
    // Hang guard, half again the expected run
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic reset_dut(input int n);
        sys_rst_i = 1'b1;
        tick(n);
        sys_rst_i = 1'b0;
        tick(1);
    endtask
    task automatic load_rate(input logic [3:0] c);
        rate_sel_i = c;
        rate_load_i = 1'b1;
        tick(1);
        rate_load_i = 1'b0;
        tick(1);
    endtask
    // Valid stays up until the edge that sees ready
    task automatic put_byte(input logic [7:0] d);
        tx_byte_i.data = d;
        tx_byte_i.valid = 1'b1;
        while (tx_ready_o !== 1'b1)
            tick(1);
        tick(1);
        tx_byte_i.valid = 1'b0;
        tick(1);
    endtask
    // Every rate code timed on its start bit; reset mid-frame restores defaults
    task automatic test_rates();
        int unsigned rates[9] = '{ghp_pkg::BAUD_9600, ghp_pkg::BAUD_19200, ghp_pkg::BAUD_38400,
            ghp_pkg::BAUD_57600, ghp_pkg::BAUD_115200, ghp_pkg::BAUD_230400, ghp_pkg::BAUD_460800,
            ghp_pkg::BAUD_921600, ghp_pkg::BAUD_3000000};
        int n;
        for (int c = 0; c < 9; c++)
        begin
            load_rate(4'(c));
            chk("rate_sel", rate_sel_o, 32'(c));
            load_rate(4'hF);
            chk("rate_sel_kept", rate_sel_o, 32'(c));
            put_byte(8'hA5);
            n = 0;
            while (uart_tx_o === 1'b0 && n < 25000)
            begin
                n++;
                tick(1);
            end
            chk("bit_cycles", 32'(n), ghp_pkg::CLK_HZ / rates[c]);
            reset_dut(2);
            chk("tx_after_rst", uart_tx_o, 32'h1);
            chk("rate_after_rst", rate_sel_o, 32'h0);
        end
        $display("rates done");
    endtask
    // Two reports back to back at the fastest rate
    task automatic test_tx();
        load_rate(4'h8);
        tick(800);
        host.got.delete();
        put_byte(8'h3C);
        put_byte(8'hC1);
        tick(900);
        chk("tx_count", 32'(host.got.size()), 32'h2);
        chk("tx_first", host.got[0], 32'h3C);
        chk("tx_second", host.got[1], 32'hC1);
        $display("tx done");
    endtask
    task automatic rx_case(input logic [7:0] d, input logic stop);
        logic v = 1'b0;
        logic e = 1'b0;
        logic [7:0] q = 8'h00;
        fork
            host.send_byte(d, stop);
            for (int k = 0; k < 900; k++)
            begin
                if (rx_byte_o.valid === 1'b1)
                    q = rx_byte_o.data;
                v = v | (rx_byte_o.valid === 1'b1);
                e = e | (rx_frame_err_o === 1'b1);
                tick(1);
            end
        join
        chk("rx_valid", v, stop);
        chk("rx_frame_err", e, !stop);
        chk("rx_data", q, stop ? d : 8'h00);
    endtask
    task automatic test_i2c(input logic [6:0] a, input logic exp);
        logic ack;
        host.i2c_probe(a, ack);
        chk("i2c_ack", ack, exp);
    endtask
    task automatic pps_count(input int exp);
        int n;
        n = 0;
        repeat (300)
        begin
            n += pulse_per_second_output_o === 1'b1;
            tick(1);
        end
        chk("pps_high_cycles", 32'(n), 32'(exp));
    endtask
    task automatic set_pps(input logic en, input logic [31:0] w);
        pps_cfg_i = {en, 32'h00000064, w, 32'h00000005};
        pps_cfg_load_i = 1'b1;
        tick(1);
        pps_cfg_load_i = 1'b0;
        tick(3);
    endtask
    // Pulse gated by fix, then width and disable through configuration
    task automatic test_pps();
        set_pps(1'b1, 32'h0000000A);
        pps_count(0);
        fix_3d_i = 1'b1;
        tick(3);
        pps_count(30);
        set_pps(1'b1, 32'h00000019);
        pps_count(75);
        set_pps(1'b0, 32'h00000019);
        pps_count(0);
        set_pps(1'b1, 32'h0000000A);
        $display("pps done");
    endtask
    // Hold pin low then released; periodic mode also drops the status
    task automatic test_power();
        chk("active_idle", active_o, 32'h1);
        host.hold_low = 1'b1;
        tick(8);
        chk("rtc_in", rtc_mode_o, 32'h1);
        chk("active_rtc", active_o, 32'h0);
        chk("tx_ready_rtc", tx_ready_o, 32'h0);
        pps_count(0);
        test_i2c(7'h2A, 1'b0);
        host.hold_low = 1'b0;
        tick(8);
        chk("rtc_out", rtc_mode_o, 32'h0);
        chk("active_back", active_o, 32'h1);
        periodic_mode_i = 1'b1;
        tick(4);
        chk("active_periodic", active_o, 32'h0);
        periodic_mode_i = 1'b0;
        tick(4);
        chk("active_full", active_o, 32'h1);
        $display("power done");
    endtask
    initial
    begin
        reset_dut(12);
        chk("rate_default", rate_sel_o, 32'h0);
        test_rates();
        test_tx();
        rx_case(8'h96, 1'b1);
        rx_case(8'h5A, 1'b0);
        rx_case(8'hFF, 1'b1);
        $display("rx done");
        test_i2c(ghp_pkg::TGT_ADDR_RESET, 1'b1);
        test_i2c(7'h11, 1'b0);
        tgt_addr_i = 7'h2A;
        tgt_addr_load_i = 1'b1;
        tick(1);
        tgt_addr_load_i = 1'b0;
        test_i2c(7'h2A, 1'b1);
        test_i2c(ghp_pkg::TGT_ADDR_RESET, 1'b0);
        $display("i2c done");
        test_pps();
        test_power();
        give_verdict();
    end
endmodule
